// File: verilog/hrs_pkg.sv
// Package for the home return sequencer: constants, states and carriers.
// Assumes a 50 MHz reference clock and a single top module using it.
package hrs_pkg;

    localparam int unsigned CLK_HZ = 50_000_000;
    // Ramp step period in microseconds; one velocity step per tick
    localparam int unsigned RAMP_TICK_US = 10;
    localparam int unsigned RAMP_TICK_CYC = (CLK_HZ / 1_000_000) * RAMP_TICK_US;
    // Stop-to-restart pause length in ramp ticks
    localparam int unsigned PAUSE_TICKS = 4;
    localparam logic [7:0] ALARM_NO_DOG = 8'h5A;
    localparam logic [7:0] ALARM_NONE = 8'h00;
    localparam logic [2:0] MODE_HOMING = 3'h2;
    localparam logic [31:0] POS_RESET = 32'h0000_0000;
    localparam logic [15:0] VEL_RESET = 16'h0000;

    typedef enum logic [3:0] {
        HRS_IDLE,
        HRS_SEEK,
        HRS_REVERSE,
        HRS_PASS_DOG,
        HRS_PAUSE,
        HRS_CREEP,
        HRS_WAIT_Z,
        HRS_SHIFT,
        HRS_AUTO_POS,
        HRS_STOP_ALARM
    } hrs_state_t;

    // Homing configuration bundle
    typedef struct packed {
        logic dog_polarity;
        logic dir_decrease;
        logic auto_return_en;
        logic [15:0] home_speed;
        logic [15:0] creep_speed;
        logic [15:0] accel_step;
        logic [15:0] decel_step;
        logic [31:0] shift_amount;
        logic [31:0] home_address;
    } hrs_cfg_t;

    // Field inputs before synchronisation
    typedef struct packed {
        logic dog_raw;
        logic z_phase;
        logic limit_fwd;
        logic limit_rev;
    } hrs_field_t;

    // One velocity step towards tgt, never past it
    function automatic logic [15:0] ramp(input logic [15:0] cur,
        input logic [15:0] tgt, input logic [15:0] up, input logic [15:0] dn);
        logic [16:0] sum;
        sum = {1'b0, cur} + {1'b0, up};
        if (cur < tgt) begin
            ramp = (sum[15:0] > tgt || sum[16]) ? tgt : sum[15:0];
        end else begin
            ramp = (cur - tgt > dn) ? cur - dn : tgt;
        end
    endfunction : ramp

endpackage : hrs_pkg

// File: verilog/hrs_home_return_sequencer.sv
// Home return sequencer: dog search, creep, Z capture, shift, auto return.
// Assumes field inputs are asynchronous pins and cfg is static while busy.
`timescale 1ns/1ps

// Operation
// - Dog active on open contact at polarity 0, closed contact at 1.
// - Ramp up with homing accel, down with homing decel constant.
// - Home point is first Z after dog rear end plus shift amount.
// - On completion load current position with home address.
// - Starting on or beyond dog, do automatic return before homing; cradle type starting on dog creeps to first Z without a return instead.
// - Move in homing direction, reverse when that limit switch activates.
// - Automatic return stops past dog front end, then homing restarts.
// - No dog found, halt at opposite limit and raise alarm 90.
// - Software travel limits disabled while automatic return in use.
// - Reverse start in homing mode launches fast positioning to home.
// - Auto positioning uses homing speed and homing time constants.
// - Dog cradle homing takes first Z after dog front end.
module hrs_home_return_sequencer (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic op_mode_sel_bit0,
    input wire logic op_mode_sel_bit1,
    input wire logic op_mode_sel_bit2,
    input wire logic forward_rotation_start,
    input wire logic reverse_rotation_start,
    input wire logic cradle_type,
    input wire logic absolute_system,
    input wire hrs_pkg::hrs_cfg_t cfg,
    input wire hrs_pkg::hrs_field_t field,
    output logic [31:0] cur_pos_ff,
    output logic signed [16:0] cmd_vel_ff,
    output logic busy_ff,
    output logic home_done_ff,
    output logic home_valid_ff,
    output logic homing_no_dog_alarm_ff,
    output logic [7:0] alarm_code_ff,
    output logic soft_limit_en_ff
);

    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic [2:0] start_s1_ff;
    logic [2:0] start_s2_ff;
    logic fstart_d_ff;
    logic rstart_d_ff;
    logic dog_d_ff;
    logic z_d_ff;
    hrs_pkg::hrs_state_t state_ff;
    hrs_pkg::hrs_state_t nxt_state;
    logic [15:0] speed_ff;
    logic [15:0] target_ff;
    logic dir_neg_ff;
    logic [31:0] remain_ff;
    logic [31:0] tick_cnt_ff;
    logic [3:0] pause_ff;
    logic left_dog_ff;

    // Double-flop all asynchronous pins
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
            start_s1_ff <= 3'h0;
            start_s2_ff <= 3'h0;
        end else begin
            sync1_ff <= {field.dog_raw, field.z_phase, field.limit_fwd,
                         field.limit_rev};
            sync2_ff <= sync1_ff;
            start_s1_ff <= {forward_rotation_start, reverse_rotation_start,
                            op_mode_sel_bit1 & ~op_mode_sel_bit0
                            & ~op_mode_sel_bit2};
            start_s2_ff <= start_s1_ff;
        end
    end

    // polarity 0 means open contact is active
    wire dog_active = cfg.dog_polarity ? sync2_ff[3] : ~sync2_ff[3];
    wire z_now = sync2_ff[2];
    wire lim_fwd = sync2_ff[1];
    wire lim_rev = sync2_ff[0];
    wire mode_homing = start_s2_ff[0];
    wire fstart = start_s2_ff[2];
    wire rstart = start_s2_ff[1];
    wire fstart_edge = fstart & ~fstart_d_ff & mode_homing;
    // reverse start launches automatic positioning to home
    wire rstart_edge = rstart & ~rstart_d_ff & mode_homing;
    wire z_rise = z_now & ~z_d_ff;
    wire dog_fall = ~dog_active & dog_d_ff;
    wire dog_rise = dog_active & ~dog_d_ff;
    wire tick = (tick_cnt_ff == 32'(hrs_pkg::RAMP_TICK_CYC - 1));
    wire lim_home_dir = cfg.dir_decrease ? lim_rev : lim_fwd;
    wire lim_opp_dir = cfg.dir_decrease ? lim_fwd : lim_rev;
    wire stopped = (speed_ff == 16'h0000);
    wire [31:0] auto_dist = cur_pos_ff - cfg.home_address;
    wire [31:0] step = {16'h0000, speed_ff};
    wire remain_done = (remain_ff <= step);
    // Last step of a counted move lands exactly on its end point
    wire exact_move = (state_ff == hrs_pkg::HRS_SHIFT
        || state_ff == hrs_pkg::HRS_AUTO_POS) && remain_done;
    wire [31:0] move = exact_move ? remain_ff : step;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            hrs_pkg::HRS_IDLE: begin
                if (rstart_edge && (home_valid_ff || absolute_system)) begin
                    nxt_state = hrs_pkg::HRS_AUTO_POS;
                end else if (fstart_edge) begin
                    nxt_state = hrs_pkg::HRS_SEEK;
                end
            end
            hrs_pkg::HRS_SEEK: begin
                // dog already under axis at a non-cradle start triggers a return
                if (dog_active && !cradle_type && cfg.auto_return_en
                    && speed_ff == 16'h0000 && !left_dog_ff) begin
                    nxt_state = hrs_pkg::HRS_REVERSE;
                // reverse at limit in the homing direction
                end else if (lim_home_dir && cfg.auto_return_en) begin
                    nxt_state = hrs_pkg::HRS_REVERSE;
                end else if (dog_active) begin
                    nxt_state = hrs_pkg::HRS_CREEP;
                end
            end
            hrs_pkg::HRS_REVERSE: begin
                if (lim_opp_dir) begin
                    nxt_state = hrs_pkg::HRS_STOP_ALARM;
                end else if (dog_active) begin
                    nxt_state = hrs_pkg::HRS_PASS_DOG;
                end
            end
            hrs_pkg::HRS_PASS_DOG: begin
                // stop once past the dog front end
                if (lim_opp_dir) begin
                    nxt_state = hrs_pkg::HRS_STOP_ALARM;
                end else if (!dog_active) begin
                    nxt_state = hrs_pkg::HRS_PAUSE;
                end
            end
            hrs_pkg::HRS_PAUSE: begin
                if (stopped && pause_ff == 4'(hrs_pkg::PAUSE_TICKS)) begin
                    nxt_state = hrs_pkg::HRS_SEEK;
                end
            end
            hrs_pkg::HRS_CREEP: begin
                // cradle takes first Z after front end
                if (cradle_type && z_rise) begin
                    nxt_state = hrs_pkg::HRS_SHIFT;
                end else if (!cradle_type && (dog_fall || left_dog_ff)) begin
                    nxt_state = hrs_pkg::HRS_WAIT_Z;
                end
            end
            hrs_pkg::HRS_WAIT_Z: begin
                // first Z after rear end starts the shift
                if (z_rise) begin
                    nxt_state = hrs_pkg::HRS_SHIFT;
                end
            end
            hrs_pkg::HRS_SHIFT, hrs_pkg::HRS_AUTO_POS: begin
                if (remain_ff == 32'h0000_0000 && stopped) begin
                    nxt_state = hrs_pkg::HRS_IDLE;
                end
            end
            hrs_pkg::HRS_STOP_ALARM: begin
                if (stopped && fstart_edge) begin
                    nxt_state = hrs_pkg::HRS_IDLE;
                end
            end
            default: nxt_state = hrs_pkg::HRS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= hrs_pkg::HRS_IDLE;
            fstart_d_ff <= 1'b0;
            rstart_d_ff <= 1'b0;
            dog_d_ff <= 1'b0;
            z_d_ff <= 1'b0;
            tick_cnt_ff <= 32'h0000_0000;
            left_dog_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            fstart_d_ff <= fstart;
            rstart_d_ff <= rstart;
            dog_d_ff <= dog_active;
            z_d_ff <= z_now;
            tick_cnt_ff <= tick ? 32'h0000_0000 : tick_cnt_ff + 32'h1;
            if (state_ff == hrs_pkg::HRS_IDLE) begin
                left_dog_ff <= 1'b0;
            end else if (dog_fall || dog_rise) begin
                left_dog_ff <= dog_fall;
            end
        end
    end

    // Target speed and direction per state
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            target_ff <= hrs_pkg::VEL_RESET;
            dir_neg_ff <= 1'b0;
        end else begin
            case (nxt_state)
                // homing speed while searching for the dog
                hrs_pkg::HRS_SEEK: begin
                    target_ff <= cfg.home_speed;
                    dir_neg_ff <= cfg.dir_decrease;
                end
                hrs_pkg::HRS_REVERSE, hrs_pkg::HRS_PASS_DOG: begin
                    target_ff <= cfg.home_speed;
                    dir_neg_ff <= ~cfg.dir_decrease;
                end
                // creep speed after the dog is seen
                hrs_pkg::HRS_CREEP, hrs_pkg::HRS_WAIT_Z,
                hrs_pkg::HRS_SHIFT: begin
                    target_ff <= exact_move ? 16'h0000 : cfg.creep_speed;
                    dir_neg_ff <= cfg.dir_decrease;
                end
                hrs_pkg::HRS_AUTO_POS: begin
                    target_ff <= remain_done ? 16'h0000 : cfg.home_speed;
                    dir_neg_ff <= ~auto_dist[31] & (auto_dist != 32'h0);
                end
                default: target_ff <= 16'h0000;
            endcase
        end
    end

    // ramp speed on each tick with homing constants, except zero at once on entry to alarm stop
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            speed_ff <= hrs_pkg::VEL_RESET;
            pause_ff <= 4'h0;
        end else begin
            if (nxt_state == hrs_pkg::HRS_STOP_ALARM) begin
                speed_ff <= 16'h0000;
            end else if (tick) begin
                speed_ff <= hrs_pkg::ramp(speed_ff, target_ff, cfg.accel_step,
                                 cfg.decel_step);
            end
            if (state_ff != hrs_pkg::HRS_PAUSE) begin
                pause_ff <= 4'h0;
            end else if (tick && stopped
                         && pause_ff != 4'(hrs_pkg::PAUSE_TICKS)) begin
                pause_ff <= pause_ff + 4'h1;
            end
        end
    end

    // Position tracking, shift distance and completion load
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cur_pos_ff <= hrs_pkg::POS_RESET;
            remain_ff <= 32'h0000_0000;
            cmd_vel_ff <= 17'sh00000;
            busy_ff <= 1'b0;
            home_done_ff <= 1'b0;
            home_valid_ff <= 1'b0;
            homing_no_dog_alarm_ff <= 1'b0;
            alarm_code_ff <= hrs_pkg::ALARM_NONE;
            soft_limit_en_ff <= 1'b1;
        end else begin
            home_done_ff <= 1'b0;
            cmd_vel_ff <= (nxt_state == hrs_pkg::HRS_STOP_ALARM) ? 17'sh00000
                        : dir_neg_ff ? -$signed({1'b0, speed_ff})
                                     : $signed({1'b0, speed_ff});
            if (tick) begin
                cur_pos_ff <= dir_neg_ff ? cur_pos_ff - move
                                         : cur_pos_ff + move;
                remain_ff <= remain_done ? 32'h0000_0000 : remain_ff - step;
            end
            if (nxt_state == hrs_pkg::HRS_SHIFT
                && state_ff != hrs_pkg::HRS_SHIFT) begin
                remain_ff <= cfg.shift_amount;
            end
            if (nxt_state == hrs_pkg::HRS_AUTO_POS
                && state_ff == hrs_pkg::HRS_IDLE) begin
                remain_ff <= auto_dist[31] ? -auto_dist : auto_dist;
            end
            if (state_ff == hrs_pkg::HRS_SHIFT
                && nxt_state == hrs_pkg::HRS_IDLE) begin
                cur_pos_ff <= cfg.home_address;
                home_done_ff <= 1'b1;
                home_valid_ff <= 1'b1;
            end
            // alarm on no dog during return
            if (nxt_state == hrs_pkg::HRS_STOP_ALARM) begin
                homing_no_dog_alarm_ff <= 1'b1;
                alarm_code_ff <= hrs_pkg::ALARM_NO_DOG;
            end else if (nxt_state == hrs_pkg::HRS_IDLE) begin
                homing_no_dog_alarm_ff <= 1'b0;
                alarm_code_ff <= hrs_pkg::ALARM_NONE;
            end
            busy_ff <= (nxt_state != hrs_pkg::HRS_IDLE);
            // soft limits off while auto return enabled
            soft_limit_en_ff <= ~cfg.auto_return_en;
        end
    end

endmodule : hrs_home_return_sequencer

// File: verif/hrs_field_model.sv
// Field-side model: proximity dog, encoder Z phase and limit switches.
// Assumes raw dog high means a closed contact; positions in command units.
`timescale 1ns/1ps
module hrs_field_model #(
    parameter logic [31:0] DOG_LO = 32'h0000_2000,
    parameter logic [31:0] DOG_HI = 32'h0000_2800,
    parameter int LIM_FWD = 24576,
    parameter int LIM_REV = -8192
) (
    input wire logic ref_clk,
    input wire logic [31:0] cur_pos,
    input wire logic dog_polarity,
    input wire logic dog_present,
    output hrs_pkg::hrs_field_t field
);
    logic [23:0] last_cell = 24'h000000;
    int z_left = 0;
    logic dog_on;
    assign dog_on = dog_present && cur_pos >= DOG_LO && cur_pos < DOG_HI;
    assign field = '{dog_raw: dog_on ? dog_polarity : !dog_polarity,
                     z_phase: z_left != 0,
                     limit_fwd: $signed(cur_pos) >= LIM_FWD,
                     limit_rev: $signed(cur_pos) <= LIM_REV};
    // one 4-cycle Z pulse each time the position moves into a new cell, however many cells it jumps
    always @(posedge ref_clk) begin
        if (cur_pos[31:8] != last_cell) z_left <= 4;
        else if (z_left != 0) z_left <= z_left - 1;
        last_cell <= cur_pos[31:8];
    end
endmodule : hrs_field_model

// File: verif/hrs_home_return_sequencer_chk.sv
// Port checker for the home return sequencer.
// Assumes mode bits stay steady around each start pulse.
`timescale 1ns/1ps
module hrs_home_return_sequencer_chk (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic op_mode_sel_bit0,
    input wire logic op_mode_sel_bit1,
    input wire logic op_mode_sel_bit2,
    input wire logic forward_rotation_start,
    input wire logic reverse_rotation_start,
    input wire logic cradle_type,
    input wire logic absolute_system,
    input wire hrs_pkg::hrs_cfg_t cfg,
    input wire hrs_pkg::hrs_field_t field,
    input wire logic [31:0] cur_pos_ff,
    input wire logic signed [16:0] cmd_vel_ff,
    input wire logic busy_ff,
    input wire logic home_done_ff,
    input wire logic home_valid_ff,
    input wire logic homing_no_dog_alarm_ff,
    input wire logic [7:0] alarm_code_ff,
    input wire logic soft_limit_en_ff
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    wire homing_mode = {op_mode_sel_bit2, op_mode_sel_bit1, op_mode_sel_bit0}
        == hrs_pkg::MODE_HOMING;
    wire signed [16:0] top_vel = $signed({1'b0, cfg.home_speed});
    wire idle_ok = !busy_ff && !homing_no_dog_alarm_ff;

    property p_soft_limit;
        $past(reset_n) && $stable(cfg.auto_return_en)
            |-> soft_limit_en_ff == !cfg.auto_return_en;
    endproperty
    a_soft_limit: assert property (p_soft_limit)
        else $error("soft limit enable wrong");
    property p_alarm_code;
        alarm_code_ff == (homing_no_dog_alarm_ff ? hrs_pkg::ALARM_NO_DOG
            : hrs_pkg::ALARM_NONE);
    endproperty
    a_alarm_code: assert property (p_alarm_code)
        else $error("alarm code wrong");
    property p_alarm_stop;
        homing_no_dog_alarm_ff |-> cmd_vel_ff == 17'sh0 && !home_done_ff;
    endproperty
    a_alarm_stop: assert property (p_alarm_stop)
        else $error("axis moving under alarm");
    property p_done_pos;
        home_done_ff |-> cur_pos_ff == cfg.home_address && cmd_vel_ff == 17'sh0;
    endproperty
    a_done_pos: assert property (p_done_pos)
        else $error("position not home address at completion");
    property p_done_pulse;
        home_done_ff |=> !home_done_ff && home_valid_ff;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("completion pulse or home valid wrong");
    property p_fwd_start;
        $rose(forward_rotation_start) && homing_mode && idle_ok
            ##1 forward_rotation_start [*3] |-> ##[0:4] busy_ff;
    endproperty
    a_fwd_start: assert property (p_fwd_start)
        else $error("homing start not taken");
    property p_rev_refused;
        $rose(reverse_rotation_start) && !home_valid_ff && !absolute_system
            && !busy_ff |=> !busy_ff [*8];
    endproperty
    a_rev_refused: assert property (p_rev_refused)
        else $error("positioning started without home");
    property p_rev_start;
        $rose(reverse_rotation_start) && homing_mode && home_valid_ff && idle_ok
            ##1 reverse_rotation_start [*3] |-> ##[0:4] busy_ff;
    endproperty
    a_rev_start: assert property (p_rev_start)
        else $error("positioning to home not started");
    property p_vel_bound;
        busy_ff |-> cmd_vel_ff <= top_vel && cmd_vel_ff >= -top_vel;
    endproperty
    a_vel_bound: assert property (p_vel_bound)
        else $error("velocity above homing speed");
endmodule : hrs_home_return_sequencer_chk

bind hrs_home_return_sequencer hrs_home_return_sequencer_chk i_chk (
    .ref_clk(ref_clk), .reset_n(reset_n), .op_mode_sel_bit0(op_mode_sel_bit0),
    .op_mode_sel_bit1(op_mode_sel_bit1), .op_mode_sel_bit2(op_mode_sel_bit2),
    .forward_rotation_start(forward_rotation_start),
    .reverse_rotation_start(reverse_rotation_start),
    .cradle_type(cradle_type), .absolute_system(absolute_system),
    .cfg(cfg), .field(field), .cur_pos_ff(cur_pos_ff),
    .cmd_vel_ff(cmd_vel_ff), .busy_ff(busy_ff), .home_done_ff(home_done_ff),
    .home_valid_ff(home_valid_ff),
    .homing_no_dog_alarm_ff(homing_no_dog_alarm_ff),
    .alarm_code_ff(alarm_code_ff), .soft_limit_en_ff(soft_limit_en_ff));

// File: verif/tb.sv
// Self-checking bench for the home return sequencer.
// Assumes the field model stands in for dog, encoder and limit switches.
`timescale 1ns/1ps
module tb;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] mode = 3'h0;
    logic fwd = 1'b0;
    logic rev = 1'b0;
    logic dog_present = 1'b1;
    logic cradle = 1'b0;
    hrs_pkg::hrs_cfg_t cfg = '0;
    hrs_pkg::hrs_field_t field;
    logic [31:0] cur_pos;
    logic signed [16:0] cmd_vel;
    logic busy, done, valid, alarm, soft_en;
    logic [7:0] code;
    int miscompares = 0;
    int checks = 0;
    bit got;

    initial forever #10 ref_clk = ~ref_clk;

    hrs_home_return_sequencer i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .op_mode_sel_bit0(mode[0]), .op_mode_sel_bit1(mode[1]),
        .op_mode_sel_bit2(mode[2]), .forward_rotation_start(fwd),
        .reverse_rotation_start(rev), .cradle_type(cradle),
        .absolute_system(1'b0), .cfg(cfg), .field(field), .cur_pos_ff(cur_pos),
        .cmd_vel_ff(cmd_vel), .busy_ff(busy), .home_done_ff(done),
        .home_valid_ff(valid), .homing_no_dog_alarm_ff(alarm),
        .alarm_code_ff(code), .soft_limit_en_ff(soft_en));
    hrs_field_model i_field (.ref_clk(ref_clk), .cur_pos(cur_pos),
        .dog_polarity(cfg.dog_polarity), .dog_present(dog_present),
        .field(field));

    function automatic logic [7:0] exp_code(bit al);
        return al ? hrs_pkg::ALARM_NO_DOG : hrs_pkg::ALARM_NONE;
    endfunction : exp_code
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic step(int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask : step
    task automatic wait_for(int kind, int max);
        got = 0;
        for (int i = 0; i < max && !got; i++) begin
            step(1);
            got = kind == 1 ? alarm === 1'b1
                : kind == 0 ? done === 1'b1 : i > 8 && busy === 1'b0;
        end
    endtask : wait_for
    task automatic summarize();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (60000) @(posedge ref_clk);
        miscompares++;
        summarize();
    end

    initial begin
        void'($urandom(34413));
        step(4);
        check("soft_limit_en in reset", soft_en, 1);
        reset_n = 1'b1;
        step(2);
        check("soft_limit_en", soft_en, 1);
        for (int m = 0; m < 8; m++) begin
            if (m == hrs_pkg::MODE_HOMING) continue;
            mode = m[2:0];
            fwd = 1'b1;
            step(8);
            fwd = 1'b0;
            step(2);
            check("busy other mode", busy, 0);
        end
        mode = hrs_pkg::MODE_HOMING;
        rev = 1'b1;
        step(8);
        rev = 1'b0;
        step(2);
        check("busy without home", busy, 0);
        $display("test refusals done");
        cfg.dog_polarity = 1'($urandom_range(1, 0));
        cfg.home_speed = 16'h1000;
        cfg.accel_step = 16'h1000;
        cfg.decel_step = 16'h1000;
        cfg.creep_speed = 16'h0200;
        cfg.shift_amount = 32'($urandom_range(255, 64));
        cfg.home_address = $urandom;
        fwd = 1'b1;
        wait_for(0, 10000);
        fwd = 1'b0;
        check("homing completed", got, 1);
        check("position at completion", cur_pos, cfg.home_address);
        step(1);
        check("home valid", valid, 1);
        check("alarm code clear", code, exp_code(0));
        $display("test homing done");
        cfg.home_address = cfg.home_address + 32'h0000_3000;
        rev = 1'b1;
        wait_for(2, 6000);
        rev = 1'b0;
        check("positioning completed", got, 1);
        check("position after positioning", cur_pos, cfg.home_address);
        $display("test positioning done");
        reset_n = 1'b0;
        cradle = 1'b1;
        step(4);
        reset_n = 1'b1;
        step(2);
        fwd = 1'b1;
        wait_for(0, 10000);
        fwd = 1'b0;
        check("cradle homing completed", got, 1);
        check("cradle position", cur_pos, cfg.home_address);
        $display("test cradle homing done");
        reset_n = 1'b0;
        cradle = 1'b0;
        cfg.auto_return_en = 1'b1;
        cfg.home_speed = 16'h4000;
        cfg.accel_step = 16'h4000;
        cfg.decel_step = 16'h4000;
        dog_present = 1'b0;
        step(4);
        reset_n = 1'b1;
        step(2);
        check("soft_limit_en auto return", soft_en, 0);
        fwd = 1'b1;
        wait_for(1, 6000);
        fwd = 1'b0;
        check("no dog alarm", alarm, 1);
        check("alarm code", code, exp_code(1));
        check("velocity at alarm", cmd_vel, 0);
        $display("test no dog alarm done");
        summarize();
    end
endmodule : tb
